//--- core/spi_cmd_pkg.sv
// Package: opcodes, status field layout and reset values of the serial command port
package spi_cmd_pkg;
  localparam logic [7:0] OP_SET_LATCH    = 8'h06;
  localparam logic [7:0] OP_CLEAR_LATCH  = 8'h04;
  localparam logic [7:0] OP_STATUS_READ  = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_READ         = 8'h03;
  localparam logic [7:0] OP_QUICK_READ   = 8'h0b;
  localparam logic [7:0] OP_WRITE        = 8'h02;
  localparam logic [7:0] OP_IDENT_READ   = 8'h9f;
  localparam logic [7:0] OP_SLEEP        = 8'hb9;
  // Status register bit positions
  localparam int BIT_BUSY      = 0;
  localparam int BIT_LATCH     = 1;
  localparam int BIT_GUARD_LO  = 2;
  localparam int BIT_GUARD_HI  = 3;
  localparam int BIT_LOCK      = 7;
  localparam logic [1:0] GUARD_RESET = 2'h0;
  localparam logic       LOCK_RESET  = 1'b0;
  localparam logic       LATCH_RESET = 1'b0;
  localparam logic [2:0] LAST_BIT    = 3'h7;
  localparam logic [4:0] ADDR_BYTES_BITS = 5'h17;
  typedef enum logic [2:0] {ST_OPCODE, ST_ADDR, ST_DUMMY, ST_DATA_IN, ST_DATA_OUT,
                            ST_STATUS_IN, ST_IGNORE} phase_type;
endpackage

//--- core/pin_sync.sv
// Two-stage synchroniser for one pin input
`timescale 1ns/10ps
`default_nettype none
module pin_sync
  import spi_cmd_pkg::*;
#(
  parameter logic RESET_VALUE = 1'b0
)
(
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic pin_in,
  output logic      pin_out
);
  logic meta_r;
  logic meta_nxt;
  logic out_r;
  logic out_nxt;

  always_comb
  begin
    meta_nxt = pin_in;
    out_nxt  = meta_r;
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      meta_r <= RESET_VALUE;
      out_r  <= RESET_VALUE;
    end
    else
    begin
      meta_r <= meta_nxt;
      out_r  <= out_nxt;
    end
  end

  assign pin_out = out_r;
endmodule
`default_nettype wire

//--- core/spi_cmd_port.sv
// Serial command port: framing, opcode decode, write latch and status register
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// (RQ1) Sample input on rising, drive output falling
// (RQ2) Chip select low starts and enables transfer
// (RQ3) Chip select high aborts any command
// (RQ4) Hold low: output released, clock/input ignored
// (RQ5) Host keeps select low during hold
// (RQ6) Host keeps protect pin steady during writes
// (RQ7) Protect pin gates block-guard bit writes
// (RQ8) Input carries opcode, address, data; output returns
// (RQ9) Unknown opcode: ignore rest of transfer
// (RQ10) Decode latch set/clear, status read/write opcodes
// (RQ11) Decode normal and quick array reads
// (RQ12) Decode array write, ident read, sleep
// (RQ13) Busy flag always reads zero
// (RQ14) Set-latch command sets latch; status shows it
// (RQ15) Clear-latch command resets the latch
// (RQ16) Writes accepted only with latch set
// (RQ17) Two guard bits select protected area
// (RQ18) Lock bit plus low protect: hardware guard
// (RQ19) Status write keeps bits 6..4, 1, 0; the port clears bit 1 (latch) after a status write
// (RQ20) Lock clear: status writable regardless of pin
// (RQ21) All fields shift most significant bit first
module spi_cmd_port
  import spi_cmd_pkg::*;
(
  // System
  input  wire logic       clk,
  input  wire logic       resetn,
  // Serial pins
  input  wire logic       cs_n,
  input  wire logic       sck,
  input  wire logic       si,
  input  wire logic       hold_n,
  input  wire logic       wp_n,
  output logic            so,
  output logic            so_oe_n,
  // Array side
  output logic [23:0]     addr,
  output logic [7:0]      wdata,
  output logic            wr_stb,
  output logic            rd_stb,
  input  wire logic [7:0] rdata,
  output logic            sleep_req,
  output logic [1:0]      area_guard,
  output logic            hw_guard_mode
);
  logic cs_s, sck_s, si_s, hold_s, wp_s;

  // Each pin through its own two flip-flops
  pin_sync #(.RESET_VALUE(1'b1)) u_cs (.clk(clk), .resetn(resetn), .pin_in(cs_n), .pin_out(cs_s));
  pin_sync #(.RESET_VALUE(1'b0)) u_sck (.clk(clk), .resetn(resetn), .pin_in(sck), .pin_out(sck_s));
  pin_sync #(.RESET_VALUE(1'b0)) u_si (.clk(clk), .resetn(resetn), .pin_in(si), .pin_out(si_s));
  pin_sync #(.RESET_VALUE(1'b1)) u_hold (.clk(clk), .resetn(resetn), .pin_in(hold_n),
                                         .pin_out(hold_s));
  pin_sync #(.RESET_VALUE(1'b1)) u_wp (.clk(clk), .resetn(resetn), .pin_in(wp_n), .pin_out(wp_s));

  ////////////////////////////////////////////////////////////////////////////////
  // State
  phase_type   phase_r, phase_nxt;
  logic        sck_d_r, sck_d_nxt;
  logic [2:0]  bit_r, bit_nxt;
  logic [4:0]  acnt_r, acnt_nxt;
  logic [7:0]  shin_r, shin_nxt;
  logic [7:0]  shout_r, shout_nxt;
  logic [7:0]  op_r, op_nxt;
  logic [23:0] addr_r, addr_nxt;
  logic [7:0]  wdata_r, wdata_nxt;
  logic        wr_r, wr_nxt, rd_r, rd_nxt;
  logic        latch_r, latch_nxt;
  logic [1:0]  guard_r, guard_nxt;
  logic        lock_r, lock_nxt;
  logic        so_r, so_nxt, oe_n_r, oe_n_nxt;
  logic        sleep_r, sleep_nxt, sleep_arm_r, sleep_arm_nxt;
  logic        hwg_r, hwg_nxt;

  logic        rise, fall, active;
  logic [7:0]  byte_in, status_val;

  // Hold freezes clock edges without ending the frame
  assign active  = !cs_s && hold_s;                                // see (RQ4)
  assign rise    = active && sck_s && !sck_d_r;                    // see (RQ1)
  assign fall    = active && !sck_s && sck_d_r;
  assign byte_in = {shin_r[6:0], si_s};                            // see (RQ21)

  always_comb
  begin
    status_val             = 8'h00;                                // see (RQ19)
    status_val[BIT_LOCK]   = lock_r;
    status_val[BIT_GUARD_HI] = guard_r[1];                         // see (RQ17)
    status_val[BIT_GUARD_LO] = guard_r[0];
    status_val[BIT_LATCH]  = latch_r;                              // see (RQ14)
    status_val[BIT_BUSY]   = 1'b0;                                 // see (RQ13)
  end

  always_comb
  begin
    phase_nxt     = phase_r;
    sck_d_nxt     = sck_s;
    bit_nxt       = bit_r;
    acnt_nxt      = acnt_r;
    shin_nxt      = shin_r;
    shout_nxt     = shout_r;
    op_nxt        = op_r;
    addr_nxt      = addr_r;
    wdata_nxt     = wdata_r;
    wr_nxt        = 1'b0;
    rd_nxt        = 1'b0;
    latch_nxt     = latch_r;
    guard_nxt     = guard_r;
    lock_nxt      = lock_r;
    so_nxt        = so_r;
    oe_n_nxt      = !(active && phase_r == ST_DATA_OUT);           // see (RQ4) (RQ9)
    sleep_nxt     = sleep_r;
    sleep_arm_nxt = sleep_arm_r;
    hwg_nxt       = lock_r && !wp_s;                               // see (RQ18)
    if (cs_s)
    begin
      // Deselect ends the command; sleep is entered on this edge
      phase_nxt = ST_OPCODE;                                       // see (RQ3)
      bit_nxt   = 3'h0;
      if (sleep_arm_r)
        sleep_nxt = 1'b1;
      sleep_arm_nxt = 1'b0;
    end
    else
    begin
      sleep_nxt = 1'b0;                                            // see (RQ2)
      if (rise)
      begin
        shin_nxt = byte_in;                                        // see (RQ8)
        bit_nxt  = bit_r + 3'h1;
        if (bit_r == LAST_BIT)
        begin
          case (phase_r)
            ST_OPCODE:
            begin
              op_nxt = byte_in;
              case (byte_in)
                OP_SET_LATCH:    latch_nxt = 1'b1;                 // see (RQ10) (RQ14)
                OP_CLEAR_LATCH:  latch_nxt = 1'b0;                 // see (RQ15)
                OP_STATUS_READ, OP_IDENT_READ:
                begin
                  // Identity byte value is arbitrary, all zeros
                  shout_nxt = (byte_in == OP_STATUS_READ) ? status_val : 8'h00;
                  phase_nxt = ST_DATA_OUT;
                end
                OP_STATUS_WRITE: phase_nxt = latch_r ? ST_STATUS_IN : ST_IGNORE; // see (RQ16)
                OP_READ, OP_QUICK_READ, OP_WRITE:                 // see (RQ11) (RQ12)
                begin
                  acnt_nxt  = 5'h0;
                  phase_nxt = ST_ADDR;
                end
                OP_SLEEP:        sleep_arm_nxt = 1'b1;             // see (RQ12)
                default:         phase_nxt = ST_IGNORE;            // see (RQ9)
              endcase
            end
            ST_STATUS_IN:
            begin
              // Hardware guard freezes the whole writable set
              if (!lock_r || wp_s)                                 // see (RQ7) (RQ20)
              begin
                lock_nxt  = byte_in[BIT_LOCK];
                guard_nxt = {byte_in[BIT_GUARD_HI], byte_in[BIT_GUARD_LO]};
              end
              latch_nxt = 1'b0;
              phase_nxt = ST_IGNORE;
            end
            ST_DATA_IN:
            begin
              wdata_nxt = byte_in;
              wr_nxt    = latch_r;                                 // see (RQ16)
            end
            default: ;
          endcase
        end
        if (phase_r == ST_ADDR)
        begin
          addr_nxt = {addr_r[22:0], si_s};                         // see (RQ21)
          acnt_nxt = acnt_r + 5'h1;
          if (acnt_r == ADDR_BYTES_BITS)
          begin
            if (op_r == OP_WRITE)
              phase_nxt = ST_DATA_IN;
            else if (op_r == OP_QUICK_READ)
              phase_nxt = ST_DUMMY;
            else
            begin
              rd_nxt    = 1'b1;
              phase_nxt = ST_DATA_OUT;
            end
          end
        end
        if (bit_r == LAST_BIT && (phase_r == ST_DUMMY || (phase_r == ST_DATA_OUT
            && op_r != OP_STATUS_READ && op_r != OP_IDENT_READ)))
        begin
          rd_nxt    = 1'b1;
          phase_nxt = ST_DATA_OUT;
        end
      end
      if (wr_r || rd_r)
        addr_nxt = addr_r + 24'h1;
      if (rd_r)
        shout_nxt = rdata;
      if (fall && phase_r == ST_DATA_OUT)
      begin
        so_nxt    = shout_r[7];                                    // see (RQ1) (RQ21)
        shout_nxt = {shout_r[6:0], shout_r[7]};
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      phase_r     <= ST_OPCODE;
      sck_d_r     <= 1'b0;
      bit_r       <= 3'h0;
      acnt_r      <= 5'h0;
      shin_r      <= 8'h00;
      shout_r     <= 8'h00;
      op_r        <= 8'h00;
      addr_r      <= 24'h000000;
      wdata_r     <= 8'h00;
      wr_r        <= 1'b0;
      rd_r        <= 1'b0;
      latch_r     <= LATCH_RESET;
      guard_r     <= GUARD_RESET;
      lock_r      <= LOCK_RESET;
      so_r        <= 1'b0;
      oe_n_r      <= 1'b1;
      sleep_r     <= 1'b0;
      sleep_arm_r <= 1'b0;
      hwg_r       <= 1'b0;
    end
    else
    begin
      phase_r     <= phase_nxt;
      sck_d_r     <= sck_d_nxt;
      bit_r       <= bit_nxt;
      acnt_r      <= acnt_nxt;
      shin_r      <= shin_nxt;
      shout_r     <= shout_nxt;
      op_r        <= op_nxt;
      addr_r      <= addr_nxt;
      wdata_r     <= wdata_nxt;
      wr_r        <= wr_nxt;
      rd_r        <= rd_nxt;
      latch_r     <= latch_nxt;
      guard_r     <= guard_nxt;
      lock_r      <= lock_nxt;
      so_r        <= so_nxt;
      oe_n_r      <= oe_n_nxt;
      sleep_r     <= sleep_nxt;
      sleep_arm_r <= sleep_arm_nxt;
      hwg_r       <= hwg_nxt;
    end
  end

  assign so            = so_r;
  assign so_oe_n       = oe_n_r;
  assign addr          = addr_r;
  assign wdata         = wdata_r;
  assign wr_stb        = wr_r;
  assign rd_stb        = rd_r;
  assign sleep_req     = sleep_r;
  assign area_guard    = guard_r;
  assign hw_guard_mode = hwg_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions
  sequence s_deselect;
    cs_s;
  endsequence
  a_release_on_hold: assert property (@(posedge clk) disable iff (!resetn) // see (RQ4)
    !hold_s |=> so_oe_n) else $error("output driven during hold");
  a_abort_on_deselect: assert property (@(posedge clk) disable iff (!resetn) // see (RQ3)
    s_deselect |=> phase_r == ST_OPCODE) else $error("command not ended");
  a_busy_zero: assert property (@(posedge clk) disable iff (!resetn) // see (RQ13)
    status_val[BIT_BUSY] == 1'b0 && status_val[6:4] == 3'h0) else $error("fixed bits set");
  a_write_needs_latch: assert property (@(posedge clk) disable iff (!resetn) // see (RQ16)
    wr_r |-> $past(latch_r)) else $error("write without latch");
  a_hw_guard_hold: assert property (@(posedge clk) disable iff (!resetn) // see (RQ7)
    (lock_r && !wp_s) |=> $stable(guard_r) && lock_r) else $error("guarded status changed");
  a_unknown_ignored: assert property (@(posedge clk) disable iff (!resetn) // see (RQ9)
    (phase_r == ST_IGNORE && !cs_s) |=> phase_r == ST_IGNORE && !wr_r && so_oe_n)
    else $error("ignore left");
  a_set_latch: assert property (@(posedge clk) disable iff (!resetn) // see (RQ14)
    (rise && bit_r == LAST_BIT && phase_r == ST_OPCODE && byte_in == OP_SET_LATCH)
    |=> latch_r) else $error("latch not set");
  a_clear_latch: assert property (@(posedge clk) disable iff (!resetn) // see (RQ15)
    (rise && bit_r == LAST_BIT && phase_r == ST_OPCODE && byte_in == OP_CLEAR_LATCH)
    |=> !latch_r) else $error("latch not cleared");
  a_hw_mode_flag: assert property (@(posedge clk) disable iff (!resetn) // see (RQ18)
    (lock_r && !wp_s) |=> hw_guard_mode) else $error("mode flag");
endmodule
`default_nettype wire

//--- verification/spi_host_model.sv
// Host model that drives the serial pins of the command port
`timescale 1ns/10ps
`default_nettype none
module spi_host_model
(
  // System
  input  wire logic clk,
  // Serial pins
  output logic      cs_n,
  output logic      sck,
  output logic      si,
  output logic      hold_n,
  output logic      wp_n,
  input  wire logic so,
  input  wire logic so_oe_n
);
  logic oe_seen;

  initial
  begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    hold_n = 1'b1;
    wp_n = 1'b1;
    oe_seen = 1'b0;
  end

  ////////////////////////////////////////////////////////////
  task automatic half(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Protect level only moves between frames
  task automatic set_wp(input logic v);
    half(1);
    wp_n = v;
  endtask

  task automatic start();
    half(1);
    cs_n = 1'b0;
    half(4);
  endtask

  task automatic stop();
    sck = 1'b0;
    half(8);
    cs_n = 1'b1;
    si = ~si;
    half(16);
  endtask

  // Data sampled just before the rising edge, after the device's lag
  task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
    oe_seen = 1'b0;
    for (int i = 7; i >= 0; i--)
    begin
      sck = 1'b0;
      si = tx[i];
      half(8);
      rx[i] = so;
      if (so_oe_n === 1'b0)
        oe_seen = 1'b1;
      sck = 1'b1;
      half(8);
    end
  endtask

  // Select stays low through the pause; clock and data wiggle meanwhile
  task automatic pause(output logic oe_in_hold);
    hold_n = 1'b0;
    half(8);
    oe_in_hold = so_oe_n;
    repeat (4)
    begin
      sck = ~sck;
      si = ~si;
      half(8);
    end
    hold_n = 1'b1;
    half(8);
  endtask
endmodule
`default_nettype wire

//--- verification/spi_cmd_port_tb.sv
// Self-checking bench of the serial command port
`timescale 1ns/10ps
`default_nettype none
module spi_cmd_port_tb;
  import spi_cmd_pkg::*;
  logic        clk, resetn, cs_n, sck, si, hold_n, wp_n, so, so_oe_n;
  logic        wr_stb, rd_stb, sleep_req, hw_guard_mode, lock, h;
  logic [1:0]  area_guard, g;
  logic [7:0]  wdata, rdata, rx, s, op, last_wdata;
  logic [23:0] addr, a, last_waddr;
  logic [31:0] seed, rv;
  int          fails, checks, cycles, wr_count, n0;
  logic [8:0]  corner [3] = '{9'h184, 9'h008, 9'h100};

  spi_cmd_port spi_cmd_port_inst (.clk(clk), .resetn(resetn), .cs_n(cs_n), .sck(sck),
    .si(si), .hold_n(hold_n), .wp_n(wp_n), .so(so), .so_oe_n(so_oe_n), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .sleep_req(sleep_req), .area_guard(area_guard), .hw_guard_mode(hw_guard_mode));
  spi_host_model spi_host_model_inst (.clk(clk), .cs_n(cs_n), .sck(sck), .si(si),
    .hold_n(hold_n), .wp_n(wp_n), .so(so), .so_oe_n(so_oe_n));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [7:0] mem_byte(input logic [23:0] ad);
    return ad[7:0] ^ ad[15:8] ^ 8'h5a;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic xb(input logic [7:0] t);
    spi_host_model_inst.xbyte(t, rx);
  endtask

  task automatic cmd(input logic [7:0] c, input logic [7:0] d, input int n);
    spi_host_model_inst.start();
    xb(c);
    if (n > 0)
      xb(d);
    spi_host_model_inst.stop();
  endtask

  task automatic status_chk(input logic l);
    cmd(OP_STATUS_READ, 8'h00, 1);
    check(rx, {lock, 3'h0, g, l, 1'b0}, "status");
    check(so_oe_n, 1'b1, "idle output");
  endtask

  task automatic array(input logic [7:0] opc, input logic [23:0] ad, input int n,
                       input logic [7:0] d);
    spi_host_model_inst.start();
    xb(opc);
    xb(ad[23:16]);
    xb(ad[15:8]);
    xb(ad[7:0]);
    if (opc == OP_QUICK_READ)
      xb(8'h00);
    for (int k = 0; k < n; k++)
    begin
      xb(d + 8'(k));
      if (opc != OP_WRITE)
        check(rx, mem_byte(ad + 24'(k)), "array data");
    end
    spi_host_model_inst.stop();
  endtask

  // Array answers on the falling edge inside the read strobe cycle
  always @(negedge clk)
    if (rd_stb === 1'b1)
      rdata <= mem_byte(addr);

  // Strobe and address read away from the edge that launches them
  always @(negedge clk)
  begin
    cycles++;
    if (wr_stb === 1'b1)
    begin
      wr_count <= wr_count + 1;
      last_waddr <= addr;
      last_wdata <= wdata;
    end
    if (cycles == 40000)
    begin
      fails++;
      results();
    end
  end

  initial
  begin
    seed = 32'h50bf41bd;
    resetn = 1'b0;
    lock = 1'b0;
    g = 2'h0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    resetn = 1'b1;
    status_chk(1'b0);
    cmd(OP_SET_LATCH, 8'h00, 0);
    status_chk(1'b1);
    cmd(OP_CLEAR_LATCH, 8'h00, 0);
    status_chk(1'b0);
    cmd(OP_STATUS_WRITE, 8'h8c, 1);
    status_chk(1'b0);
    $display("test latch done");
    for (int k = 0; k < 8; k++)
    begin
      rv = (k < 3) ? 32'(corner[k]) : rnd();
      spi_host_model_inst.set_wp(rv[8]);
      cmd(OP_SET_LATCH, 8'h00, 0);
      cmd(OP_STATUS_WRITE, rv[7:0], 1);
      if (!(lock && !rv[8]))
      begin
        lock = rv[7];
        g = rv[3:2];
      end
      status_chk(1'b0);
      check(area_guard, g, "guard bits");
      check(hw_guard_mode, lock & ~rv[8], "hw guard");
    end
    spi_host_model_inst.set_wp(1'b1);
    cmd(OP_SET_LATCH, 8'h00, 0);
    cmd(OP_STATUS_WRITE, 8'h00, 1);
    lock = 1'b0;
    g = 2'h0;
    $display("test status done");
    n0 = wr_count;
    a = 24'(rnd());
    array(OP_WRITE, a, 1, 8'h3c);
    check(wr_count - n0, 0, "refused write");
    cmd(OP_SET_LATCH, 8'h00, 0);
    array(OP_WRITE, a, 2, 8'hc3);
    check(wr_count - n0, 2, "write count");
    check(last_waddr, a + 24'h1, "write addr");
    check(last_wdata, 8'hc4, "write data");
    array(OP_READ, 24'(rnd()), 3, 8'h00);
    array(OP_QUICK_READ, 24'(rnd()), 3, 8'h00);
    cmd(OP_IDENT_READ, 8'h00, 1);
    check(rx, 8'h00, "ident");
    $display("test array done");
    repeat (3)
    begin
      op = 8'(rnd());
      if (op inside {8'h06, 8'h04, 8'h05, 8'h01, 8'h03, 8'h0b, 8'h02, 8'h9f, 8'hb9})
        op = 8'hff;
      cmd(op, 8'h00, 1);
      check(spi_host_model_inst.oe_seen, 1'b0, "unknown opcode");
    end
    cmd(OP_SET_LATCH, 8'h00, 0);
    spi_host_model_inst.start();
    xb(OP_STATUS_READ);
    spi_host_model_inst.pause(h);
    check(h, 1'b1, "hold output");
    xb(8'h00);
    spi_host_model_inst.stop();
    check(rx, 8'h02, "status after hold");
    cmd(OP_SLEEP, 8'h00, 0);
    check(sleep_req, 1'b1, "sleep");
    spi_host_model_inst.start();
    spi_host_model_inst.half(4);
    check(sleep_req, 1'b0, "wake");
    spi_host_model_inst.stop();
    $display("test misc done");
    results();
  end
endmodule
`default_nettype wire
